// ---- logic/step_tick_gen.sv ----
// Step tick generator: base timing step and power-of-two multiples for time limit and latency
`timescale 1ns/1ps
`include "tap_pulse_defines.svh"

module step_tick_gen #(
    parameter int BASE_STEP_CYCLES = `BASE_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Step multipliers as shift counts
    input  wire logic [2:0] tmlt_shift,
    input  wire logic [2:0] ltcy_shift,
    // One-cycle step enables
    output logic            tmlt_tick_r,
    output logic            ltcy_tick_r
);

    localparam int CW = $clog2(BASE_STEP_CYCLES + 1);

    logic [CW-1:0] base_cnt_r;     // Cycles within one base step
    logic [4:0]    pre_cnt_r;      // Base steps, wraps at 32
    logic          base_tick_w;    // Last cycle of a base step
    logic [4:0]    tmlt_mask_w;    // Low bits that must be zero for a time-limit step
    logic [4:0]    ltcy_mask_w;    // Low bits that must be zero for a latency step

    assign base_tick_w = (base_cnt_r == CW'(BASE_STEP_CYCLES - 1));
    assign tmlt_mask_w = 5'((6'h01 << tmlt_shift) - 6'h01);
    assign ltcy_mask_w = 5'((6'h01 << ltcy_shift) - 6'h01);

    // Free-running dividers; a changed rate takes effect at the next step boundary
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            base_cnt_r  <= '0;
            pre_cnt_r   <= 5'h00;
            tmlt_tick_r <= 1'b0;
            ltcy_tick_r <= 1'b0;
        end else begin
            base_cnt_r  <= base_tick_w ? '0 : CW'(base_cnt_r + 1'b1);
            if (base_tick_w) begin
                pre_cnt_r <= 5'(pre_cnt_r + 5'h01);
            end
            tmlt_tick_r <= base_tick_w && ((pre_cnt_r & tmlt_mask_w) == 5'h00);
            ltcy_tick_r <= base_tick_w && ((pre_cnt_r & ltcy_mask_w) == 5'h00);
        end
    end

endmodule

// ---- logic/tap_pulse_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the tap pulse detector
`ifndef TAP_PULSE_DEFINES_SVH
`define TAP_PULSE_DEFINES_SVH

// Register offsets on the register access port
`define OFS_PULSE_CONFIG      8'h2F
`define OFS_PULSE_SOURCE      8'h30
`define OFS_PULSE_THRESHOLD_X 8'h31
`define OFS_PULSE_THRESHOLD_Y 8'h32
`define OFS_PULSE_THRESHOLD_Z 8'h33
`define OFS_PULSE_TIME_LIMIT  8'h34
`define OFS_PULSE_LATENCY     8'h35
`define OFS_PULSE_WINDOW      8'h36

// Configuration register fields
`define CFG_DOUBLE_PULSE_ABORT  7
`define CFG_EVENT_LATCH_ENABLE  6
`define CFG_AXIS_ENABLE_MSB     5

// Source register fields
`define SRC_EVENT_ACTIVE 6
`define SRC_FLAGS_MSB    5

// Threshold field width
`define THRESHOLD_WIDTH 5

// Reset values
`define RST_PULSE_CONFIG     8'h00
`define RST_PULSE_SOURCE     7'h00
`define RST_PULSE_THRESHOLD  5'h00
`define RST_PULSE_TIME_LIMIT 8'h00
`define RST_PULSE_LATENCY    8'h00
`define RST_PULSE_WINDOW     8'h00

// Output data rate codes
`define RATE_400_HZ 3'h0
`define RATE_200_HZ 3'h1
`define RATE_100_HZ 3'h2

// Timing: the shortest step is 0.625 ms; all other steps are power-of-two multiples
`define CORE_CLK_PERIOD_NS 20
`define TIME_STEP_BASE_NS  625000
`define BASE_STEP_CYCLES   (`TIME_STEP_BASE_NS / `CORE_CLK_PERIOD_NS)

`endif

// ---- logic/tap_pulse_detector.sv ----
// Tap pulse detector: per-axis single and double tap detection with register file
//
// Behaviour
// - Config bits 5..0 enable per-axis single/double
// - Bit 6 set latches flags in source
// - Reading source register clears latched flags
// - Abort bit clear: latency pulses never abort
// - Abort bit set: pulse inside latency suspends double
// - Source bit 6 event active, bits 5..0 flags
// - Flags appear only for enabled axis and type
// - Pulse interrupt drops on status register read
// - Per-axis 5-bit thresholds, upper bits read zero
// - Threshold counts fixed on 8g scale basis
// - Pulse starts when acceleration exceeds threshold
// - Valid pulse falls back within time limit
// - Normal time-limit step follows output rate
// - Low power doubles time-limit step
// - Longest time limit is step times 255
// - Latency after first pulse ignores all pulses
// - Normal latency step follows output rate
// - Low power latency step table applies
// - Second pulse must start inside window
// - Three-bit rate code selects output rate
`timescale 1ns/1ps
`include "tap_pulse_defines.svh"

module tap_pulse_detector
    import tap_pulse_pkg::*;
#(
    parameter int SAMPLE_WIDTH     = 12,
    parameter int BASE_STEP_CYCLES = `BASE_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    // Register access port
    input  wire logic [7:0]              reg_addr,
    input  wire logic                    reg_write,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_read,
    output logic      [7:0]              reg_rdata_r,
    // Acceleration samples, two's complement in the selected full scale
    input  wire logic                    sample_valid,
    input  wire logic [SAMPLE_WIDTH-1:0] accel_x,
    input  wire logic [SAMPLE_WIDTH-1:0] accel_y,
    input  wire logic [SAMPLE_WIDTH-1:0] accel_z,
    // System mode
    input  wire logic [1:0]              full_scale,
    input  wire logic [2:0]              rate_select,
    input  wire logic                    low_power,
    // Interrupt status handshake
    input  wire logic                    status_read,
    output logic                         pulse_event_r
);

    // Magnitude of a sample rescaled to the 8g basis of the threshold field
    function automatic logic [SAMPLE_WIDTH-1:0] mag_counts(
        input logic [SAMPLE_WIDTH-1:0] smp,
        input logic [1:0]              fs
    );
        logic [SAMPLE_WIDTH-1:0] mag;
        mag = smp[SAMPLE_WIDTH-1] ? SAMPLE_WIDTH'(~smp + 1'b1) : smp;
        // One count is 2^(SAMPLE_WIDTH-6) codes at 8g; halve scale per range step
        unique case (fs)
            2'h3:    mag_counts = mag >> (SAMPLE_WIDTH - 6);
            2'h2:    mag_counts = mag >> (SAMPLE_WIDTH - 5);
            default: mag_counts = mag >> (SAMPLE_WIDTH - 4);
        endcase
    endfunction

    // Time-limit step as a power of two of the base step
    function automatic logic [2:0] tmlt_shift_of(input logic [2:0] rate, input logic lp);
        logic [2:0] s;
        unique case (rate)
            `RATE_400_HZ: s = 3'h0;
            `RATE_200_HZ: s = 3'h1;
            `RATE_100_HZ: s = 3'h2;
            default:      s = 3'h3;
        endcase
        tmlt_shift_of = 3'(s + {2'h0, lp});
    endfunction

    // Latency and window step as a power of two of the base step
    function automatic logic [2:0] ltcy_shift_of(input logic [2:0] rate, input logic lp);
        logic [2:0] s;
        unique case (rate)
            `RATE_400_HZ: s = lp ? 3'h2 : 3'h1;
            `RATE_200_HZ: s = lp ? 3'h3 : 3'h2;
            `RATE_100_HZ: s = lp ? 3'h5 : 3'h3;
            default:      s = lp ? 3'h5 : 3'h4;
        endcase
        ltcy_shift_of = s;
    endfunction

    // Register file
    logic [7:0] config_r;                     // Abort, latch enable, six axis enables
    logic [6:0] source_r;                     // Event active and six flags
    logic [6:0] source_nxt;
    logic [4:0] threshold_r [3];              // Per-axis thresholds, X Y Z
    logic [7:0] time_limit_r;                 // Pulse width limit in steps
    logic [7:0] latency_r;                    // Latency in steps
    logic [7:0] window_r;                     // Second pulse window in steps
    logic       pulse_event_nxt;

    // Register decode
    logic       wr_config_w;
    logic       wr_tmlt_w;
    logic       wr_ltcy_w;
    logic       wr_window_w;
    logic [2:0] wr_thr_w;
    logic       rd_source_w;
    logic [7:0] rd_mux_w;

    // Timing steps
    logic       tmlt_tick_w;
    logic       ltcy_tick_w;

    // Per-axis detection state
    tap_state_t st_r         [3];
    logic [7:0] cnt_r        [3];             // Step counter of the current phase
    logic       prev_above_r [3];             // Above threshold at the previous sample
    logic       lat_start_r  [3];             // A pulse started during latency
    logic       lat_abort_r  [3];             // That pulse also ended during latency
    logic       single_ev_r  [3];             // One-cycle single tap pulse
    logic       double_ev_r  [3];             // One-cycle double tap pulse
    logic       above_w      [3];
    logic       rise_w       [3];
    logic       fall_w       [3];
    logic [SAMPLE_WIDTH-1:0] accel_w [3];
    logic       ev_strobe_r;                  // Marks the cycle in which events are reported
    logic [5:0] ev_set_w;                     // Enabled events of this cycle
    logic       latch_en_w;
    logic       abort_en_w;

    assign latch_en_w = config_r[`CFG_EVENT_LATCH_ENABLE];
    assign abort_en_w = config_r[`CFG_DOUBLE_PULSE_ABORT];

    assign accel_w[0] = accel_x;
    assign accel_w[1] = accel_y;
    assign accel_w[2] = accel_z;

    // Write strobes per register
    assign wr_config_w = reg_write && (reg_addr == `OFS_PULSE_CONFIG);
    assign wr_tmlt_w   = reg_write && (reg_addr == `OFS_PULSE_TIME_LIMIT);
    assign wr_ltcy_w   = reg_write && (reg_addr == `OFS_PULSE_LATENCY);
    assign wr_window_w = reg_write && (reg_addr == `OFS_PULSE_WINDOW);
    assign wr_thr_w[0] = reg_write && (reg_addr == `OFS_PULSE_THRESHOLD_X);
    assign wr_thr_w[1] = reg_write && (reg_addr == `OFS_PULSE_THRESHOLD_Y);
    assign wr_thr_w[2] = reg_write && (reg_addr == `OFS_PULSE_THRESHOLD_Z);
    assign rd_source_w = reg_read && (reg_addr == `OFS_PULSE_SOURCE);

    // Read data selection; unmapped offsets read zero
    assign rd_mux_w =
        (reg_addr == `OFS_PULSE_CONFIG)      ? config_r                     :
        (reg_addr == `OFS_PULSE_SOURCE)      ? {1'b0, source_r}             :
        (reg_addr == `OFS_PULSE_THRESHOLD_X) ? {3'h0, threshold_r[0]}       :
        (reg_addr == `OFS_PULSE_THRESHOLD_Y) ? {3'h0, threshold_r[1]}       :
        (reg_addr == `OFS_PULSE_THRESHOLD_Z) ? {3'h0, threshold_r[2]}       :
        (reg_addr == `OFS_PULSE_TIME_LIMIT)  ? time_limit_r                 :
        (reg_addr == `OFS_PULSE_LATENCY)     ? latency_r                    :
        (reg_addr == `OFS_PULSE_WINDOW)      ? window_r                     :
                                               8'h00;

    // Writable registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            config_r     <= `RST_PULSE_CONFIG;
            time_limit_r <= `RST_PULSE_TIME_LIMIT;
            latency_r    <= `RST_PULSE_LATENCY;
            window_r     <= `RST_PULSE_WINDOW;
        end else begin
            if (wr_config_w) begin
                config_r <= reg_wdata;
            end
            if (wr_tmlt_w) begin
                time_limit_r <= reg_wdata;
            end
            if (wr_ltcy_w) begin
                latency_r <= reg_wdata;
            end
            if (wr_window_w) begin
                window_r <= reg_wdata;
            end
        end
    end

    // Threshold registers keep only the low five bits
    for (genvar t = 0; t < 3; t++) begin : g_thr
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                threshold_r[t] <= `RST_PULSE_THRESHOLD;
            end else if (wr_thr_w[t]) begin
                threshold_r[t] <= reg_wdata[`THRESHOLD_WIDTH-1:0];
            end
        end
    end

    // Read data is registered and holds until the next read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_read) begin
            reg_rdata_r <= rd_mux_w;
        end
    end

    // Step enables derived from the base step for the current rate and power mode
    step_tick_gen #(
        .BASE_STEP_CYCLES (BASE_STEP_CYCLES)
    ) i_step_tick_gen (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .tmlt_shift  (tmlt_shift_of(rate_select, low_power)),
        .ltcy_shift  (ltcy_shift_of(rate_select, low_power)),
        .tmlt_tick_r (tmlt_tick_w),
        .ltcy_tick_r (ltcy_tick_w)
    );

    // Per-axis detection
    for (genvar a = 0; a < 3; a++) begin : g_axis
        logic sgl_en_w;
        logic dbl_en_w;

        assign sgl_en_w  = config_r[2*a];
        assign dbl_en_w  = config_r[2*a+1];
        // Strictly above the programmed count starts a pulse
        assign above_w[a] = mag_counts(accel_w[a], full_scale) > SAMPLE_WIDTH'(threshold_r[a]);
        assign rise_w[a]  = sample_valid && above_w[a] && !prev_above_r[a];
        assign fall_w[a]  = sample_valid && !above_w[a];

        // Sequence: first pulse, latency, window, second pulse
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                st_r[a]         <= ST_IDLE;
                cnt_r[a]        <= 8'h00;
                prev_above_r[a] <= 1'b0;
                lat_start_r[a]  <= 1'b0;
                lat_abort_r[a]  <= 1'b0;
                single_ev_r[a]  <= 1'b0;
                double_ev_r[a]  <= 1'b0;
            end else begin
                single_ev_r[a] <= 1'b0;
                double_ev_r[a] <= 1'b0;
                if (sample_valid) begin
                    prev_above_r[a] <= above_w[a];
                end
                unique case (st_r[a])
                    ST_IDLE: begin
                        // Disabled axes never start a sequence
                        if (rise_w[a] && (sgl_en_w || dbl_en_w)) begin
                            st_r[a]  <= ST_FIRST;
                            cnt_r[a] <= 8'h00;
                        end
                    end
                    ST_FIRST: begin
                        if (fall_w[a]) begin
                            // Fell back within the limit: first pulse is valid
                            single_ev_r[a] <= sgl_en_w;
                            st_r[a]        <= ST_LATENCY;
                            cnt_r[a]       <= 8'h00;
                            lat_start_r[a] <= 1'b0;
                            lat_abort_r[a] <= 1'b0;
                        end else if (tmlt_tick_w) begin
                            // Limit of 255 steps at most, counted in time-limit steps
                            if (cnt_r[a] == time_limit_r) begin
                                st_r[a] <= ST_WAIT_LOW;
                            end else begin
                                cnt_r[a] <= 8'(cnt_r[a] + 8'h01);
                            end
                        end
                    end
                    ST_LATENCY: begin
                        // Pulses here are ignored; they are only watched for the abort option
                        if (rise_w[a]) begin
                            lat_start_r[a] <= 1'b1;
                        end
                        if (fall_w[a] && lat_start_r[a]) begin
                            lat_abort_r[a] <= 1'b1;
                        end
                        if (ltcy_tick_w || (latency_r == 8'h00)) begin
                            if (cnt_r[a] == latency_r) begin
                                cnt_r[a] <= 8'h00;
                                // Abort only when set; otherwise the window opens whenever double tap is enabled
                                if (!dbl_en_w || (abort_en_w && lat_abort_r[a])) begin
                                    st_r[a] <= ST_IDLE;
                                end else begin
                                    st_r[a] <= ST_WINDOW;
                                end
                            end else begin
                                cnt_r[a] <= 8'(cnt_r[a] + 8'h01);
                            end
                        end
                    end
                    ST_WINDOW: begin
                        if (rise_w[a]) begin
                            st_r[a]  <= ST_SECOND;
                            cnt_r[a] <= 8'h00;
                        end else if (ltcy_tick_w) begin
                            if (cnt_r[a] == window_r) begin
                                st_r[a] <= ST_IDLE;
                            end else begin
                                cnt_r[a] <= 8'(cnt_r[a] + 8'h01);
                            end
                        end
                    end
                    ST_SECOND: begin
                        // The second pulse may end after the window closes
                        if (fall_w[a]) begin
                            double_ev_r[a] <= dbl_en_w;
                            st_r[a]        <= ST_IDLE;
                        end else if (tmlt_tick_w) begin
                            if (cnt_r[a] == time_limit_r) begin
                                st_r[a] <= ST_WAIT_LOW;
                            end else begin
                                cnt_r[a] <= 8'(cnt_r[a] + 8'h01);
                            end
                        end
                    end
                    ST_WAIT_LOW: begin
                        // Too-long pulse: wait for the level to drop before re-arming
                        if (fall_w[a]) begin
                            st_r[a] <= ST_IDLE;
                        end
                    end
                    default: begin
                        st_r[a] <= ST_IDLE;
                    end
                endcase
            end
        end

        assign ev_set_w[2*a]   = single_ev_r[a];
        assign ev_set_w[2*a+1] = double_ev_r[a];
    end

    // Source register: latched flags accumulate until read, set beats a clearing read;
    // unlatched flags show the events of the latest evaluated sample only
    always_comb begin
        logic [5:0] flags;
        flags = source_r[`SRC_FLAGS_MSB:0];
        if (latch_en_w) begin
            flags = (rd_source_w ? 6'h00 : flags) | ev_set_w;
        end else if (ev_strobe_r) begin
            flags = ev_set_w;
        end else if (rd_source_w) begin
            flags = 6'h00;
        end
        source_nxt = {|flags, flags};
    end

    // Pulse interrupt level: any enabled event sets it, a status read drops it
    assign pulse_event_nxt = (status_read ? 1'b0 : pulse_event_r) | (|ev_set_w);

    // Event bookkeeping
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            source_r      <= `RST_PULSE_SOURCE;
            pulse_event_r <= 1'b0;
            ev_strobe_r   <= 1'b0;
        end else begin
            source_r      <= source_nxt;
            pulse_event_r <= pulse_event_nxt;
            ev_strobe_r   <= sample_valid;
        end
    end

endmodule

// ---- logic/tap_pulse_pkg.sv ----
// Types shared by the tap pulse detector modules
package tap_pulse_pkg;

    // Per-axis detection sequence, one-hot
    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_FIRST    = 6'h02,
        ST_LATENCY  = 6'h04,
        ST_WINDOW   = 6'h08,
        ST_SECOND   = 6'h10,
        ST_WAIT_LOW = 6'h20
    } tap_state_t;

endpackage

// ---- verif/reg_host.sv ----
// Host model driving register strobes and status reads
`timescale 1ns/1ps
module reg_host (
    // Clock
    input  wire logic       core_clk,
    // Register port
    output logic      [7:0] reg_addr,
    output logic            reg_write,
    output logic      [7:0] reg_wdata,
    output logic            reg_read,
    input  wire logic [7:0] reg_rdata_r,
    // Status acknowledge
    output logic            status_read
);
    // Idle bus at time zero
    initial begin
        reg_addr = 8'hA5;
        reg_write = 1'b0;
        reg_wdata = 8'h5A;
        reg_read = 1'b0;
        status_read = 1'b0;
    end
    // One access just after an edge; strobe stays up so calls can run back to back
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        reg_write = wr;
        reg_read = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        q = reg_rdata_r;
    endtask
    // Release; unused lines flip so stale values cannot pass
    task automatic rest();
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
        @(posedge core_clk);
        #1;
    endtask
    // Status read, drops the interrupt
    task automatic ack();
        status_read = 1'b1;
        @(posedge core_clk);
        #1;
        status_read = 1'b0;
    endtask
endmodule

// ---- verif/tap_pulse_checker.sv ----
// Port assertions of the tap pulse detector
`timescale 1ns/1ps
module tap_pulse_checker (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata_r,
    // Samples and interrupt
    input wire logic       sample_valid,
    input wire logic       status_read,
    input wire logic       pulse_event_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Read of the source register
    wire rd_src = reg_read && reg_addr == 8'h30;
    // A sample one edge back could set a flag that beats the clear; the guard only excludes a sample two edges back
    sequence s_quiet_read; rd_src && !$past(sample_valid, 2); endsequence
    sequence s_reread; rd_src; endsequence
    sequence s_cfg_write; reg_write && reg_addr == 8'h2F; endsequence
    a_src_clear: assert property (s_quiet_read ##1 s_reread |=> reg_rdata_r == 8'h00)
        else $error("source flags survived a read");
    a_cfg_readback: assert property (s_cfg_write ##1 (reg_read && reg_addr == 8'h2F)
        |=> reg_rdata_r == $past(reg_wdata, 2)) else $error("config readback differs");
    a_src_active: assert property (rd_src |=> !reg_rdata_r[7] && reg_rdata_r[6] == |reg_rdata_r[5:0])
        else $error("event active flag wrong");
    a_thresh_upper: assert property (reg_read && reg_addr inside {[8'h31:8'h33]} |=> reg_rdata_r[7:5] == 3'h0)
        else $error("threshold upper bits set");
    a_unmapped_zero: assert property (reg_read && (reg_addr < 8'h2F || reg_addr > 8'h36) |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    a_event_cause: assert property ($rose(pulse_event_r) |-> $past(sample_valid, 2))
        else $error("interrupt rose without a sample");
    a_event_drop: assert property ($fell(pulse_event_r) |-> $past(status_read))
        else $error("interrupt fell without status read");
    a_event_holds: assert property (pulse_event_r && !status_read |=> pulse_event_r)
        else $error("interrupt dropped on its own");
endmodule
bind tap_pulse_detector tap_pulse_checker i_checker (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata_r(reg_rdata_r),
    .sample_valid(sample_valid), .status_read(status_read), .pulse_event_r(pulse_event_r));

// ---- verif/tap_pulse_detector_tb.sv ----
// Self-checking testbench of the tap pulse detector
`timescale 1ns/1ps
module tap_pulse_detector_tb;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, q, q1;
    logic        reg_write, reg_read, status_read, pulse_event_r;
    logic        sample_valid = 1'b0;
    logic [11:0] accel = 12'h000;  // Same sample on every axis
    logic [1:0]  fs = 2'h3;        // Full-scale code
    logic        low_power = 1'b0;
    int          fails = 0;
    int          checks_done = 0;
    int          cycles = 0;
    always #10 core_clk = ~core_clk;
    // Short step keeps the run brief; 8g scale, 400 Hz, normal power
    tap_pulse_detector #(.BASE_STEP_CYCLES(4)) i_tap_pulse_detector (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
        .reg_rdata_r(reg_rdata_r), .sample_valid(sample_valid), .accel_x(accel), .accel_y(accel),
        .accel_z(accel), .full_scale(fs), .rate_select(3'h0), .low_power(low_power),
        .status_read(status_read), .pulse_event_r(pulse_event_r));
    reg_host u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_read(reg_read), .reg_rdata_r(reg_rdata_r), .status_read(status_read));
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n); repeat (n) @(posedge core_clk); #1; endtask
    task automatic wr(input logic [7:0] a, d); u_host.xfer(1'b1, a, d, q); u_host.rest(); endtask
    task automatic rd(input logic [7:0] a, e); u_host.xfer(1'b0, a, 8'h00, q); u_host.rest(); chk(q, e); endtask
    task automatic smp(input logic [11:0] v);
        sample_valid = 1'b1;
        accel = v;
        wt(1);
        sample_valid = 1'b0;
        accel = ~v;
    endtask
    task automatic tap(input logic [11:0] v); smp(v); wt(3); smp(12'h000); endtask
    task automatic t_regs();
        for (int a = 8'h2F; a <= 8'h36; a++) rd(8'(a), 8'h00);
        rd(8'h40, 8'h00);
        for (int a = 8'h31; a <= 8'h33; a++) begin
            wr(8'(a), 8'hFF);
            rd(8'(a), 8'h1F);
        end
        u_host.xfer(1'b1, 8'h2F, 8'h7F, q);
        u_host.xfer(1'b0, 8'h2F, 8'h00, q);
        u_host.rest();
        chk(q, 8'h7F);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
    endtask
    // Latched single tap on all axes, only X single enabled
    task automatic t_single();
        for (int a = 8'h31; a <= 8'h33; a++) wr(8'(a), 8'h02);
        wr(8'h34, 8'h0A);
        wr(8'h35, 8'h01);
        wr(8'h2F, 8'h41);
        tap(12'hE00); // Negative sample crosses by magnitude
        wt(2);
        chk({7'h0, pulse_event_r}, 8'h01);
        smp(12'h000);
        wt(30);
        u_host.xfer(1'b0, 8'h30, 8'h00, q1);
        u_host.xfer(1'b0, 8'h30, 8'h00, q);
        u_host.rest();
        chk(q1, 8'h41);
        chk(q, 8'h00);
        u_host.ack();
        chk({7'h0, pulse_event_r}, 8'h00);
    endtask
    // Pulse held past the time limit is dropped
    task automatic t_long();
        smp(12'h200);
        repeat (12) begin
            wt(8);
            smp(12'h200);
        end
        wt(3);
        smp(12'h000);
        wt(3);
        chk({7'h0, pulse_event_r}, 8'h00);
        rd(8'h30, 8'h00);
        low_power = 1'b1;
        smp(12'h200);
        wt(60);
        smp(12'h000);
        wt(2);
        chk({7'h0, pulse_event_r}, 8'h01);
        low_power = 1'b0;
        rd(8'h30, 8'h41);
        wt(40);
        u_host.ack();
    endtask
    // Unlatched flags follow the latest sample
    task automatic t_unlatched();
        wr(8'h2F, 8'h01);
        tap(12'h200);
        wt(2);
        chk({7'h0, pulse_event_r}, 8'h01);
        rd(8'h30, 8'h41);
        smp(12'h000);
        wt(3);
        rd(8'h30, 8'h00);
        u_host.ack();
        fs = 2'h1;
        wt(20);
        tap(12'h200); // At 2g this is two counts, not above
        wt(2);
        chk({7'h0, pulse_event_r}, 8'h00);
        fs = 2'h3;
    endtask
    // Tap inside latency, then one inside the window; abort off then on
    task automatic t_double();
        wr(8'h35, 8'h05);
        wr(8'h36, 8'h14);
        for (int i = 0; i < 2; i++) begin
            wt(200);
            wr(8'h2F, i ? 8'hC2 : 8'h42);
            rd(8'h30, 8'h00);
            tap(12'h200);
            wt(6);
            tap(12'h200);
            wt(40);
            tap(12'h200);
            wt(3);
            rd(8'h30, i ? 8'h00 : 8'h42);
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        t_regs();
        t_single();
        t_long();
        t_unlatched();
        t_double();
        print_verdict();
    end
endmodule
